// File: inc/mcuic_pkg.sv
// package: register map, field positions, reset values and timing for the interrupt controller
package mcuic_pkg;

  // ************************************************************
  // register map (printed offsets are not all multiples of four: kept as indices)
  // ************************************************************
  localparam logic [7:0] IDX_INTERRUPT_CONTROL    = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS     = 8'h0C;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES   = 8'h8C;
  localparam logic [7:0] IDX_CORE_OPTIONS         = 8'h81;
  localparam logic [7:0] IDX_CORE_STATUS          = 8'h90;
  localparam int         ADDR_LSB                 = 2;
  localparam int         IDX_W                    = 8;

  // ************************************************************
  // interrupt control fields
  // ************************************************************
  localparam int BIT_GIE   = 7;
  localparam int BIT_PGE   = 6;
  localparam int BIT_T0E   = 5;
  localparam int BIT_PINE  = 4;
  localparam int BIT_PCHE  = 3;
  localparam int BIT_T0F   = 2;
  localparam int BIT_PINF  = 1;
  localparam int BIT_PCHF  = 0;
  localparam int BIT_EDGE  = 6;   // edge select in the options register
  localparam int BIT_GAP   = 3;   // unimplemented peripheral bit

  // ************************************************************
  // reset values and masks
  // ************************************************************
  localparam logic [7:0] INTCTL_RST   = 8'h00;
  localparam logic [7:0] INTCTL_KEEP  = 8'h01;  // bit 0 unchanged on warm reset
  localparam logic [7:0] PERIPH_RST   = 8'h00;
  localparam logic [7:0] PERIPH_MASK  = 8'hF7;
  localparam logic [7:0] OPTIONS_RST  = 8'hFF;
  localparam logic [7:0] PORT_HI_MASK = 8'hF0;
  localparam logic [7:0] T0_MAX       = 8'hFF;
  localparam logic [12:0] IRQ_VECTOR  = 13'h0004;

  // ************************************************************
  // timing: Q phases and latency
  // ************************************************************
  localparam int         Q_PER_TCY    = 4;
  localparam logic [1:0] Q1           = 2'h0;
  localparam logic [1:0] Q4           = 2'h3;
  localparam logic [1:0] LAT_SYNC_TCY = 2'h2;  // cycles after flag before vector (3 Tcy total)

  typedef struct packed {
    logic        req;     // vector fetch request
    logic        wake;    // wake from sleep
    logic [12:0] vector;
  } mcuic_core_t;

endpackage

// File: src/mcuic_ctrl.sv
// interrupt controller for an 8-bit microcontroller core, with APB register access
`timescale 1ns/1ns
// Notes on behaviour
// [R1] global enable gates every unmasked source
// [R2] reset clears global enable
// [R3] return instruction sets global enable again
// [R4] accept: clear enable, push return, vector
// [R5] flags set regardless of enables
// [R6] latency three Tcy synchronous, three-four asynchronous
// [R7] enable-clear instruction blocks next-cycle interrupt
// [R8] pin edge per select bit sets flag
// [R9] enabled pin event wakes from sleep
// [R10] timer rollover sets timer flag, gated
// [R11] upper port change sets change flag
// [R12] change during port read may miss
// [R13] peripheral flags and enables share positions
// [R14] control register bit order fixed
// [R15] pin flag sampled at first phase
// [R16] reset values per reset kind
// [R17] only return address saved by hardware
// [R18] software clears flag before re-enabling
// [R19] wake with enable set vectors to 0004h
// [R20] ten interrupt sources accepted
// [R21] wake regardless of enable; continue or vector
// [R22] pending enabled source makes sleep a no-op
// [R23] request is gated OR of pairs
module mcuic_ctrl (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_power_on,      // high with i_srst for a power-up reset
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // event sources
  input  wire logic        i_ext_irq_pin,   // asynchronous pin
  input  wire logic [3:0]  i_port_hi_pins,  // asynchronous pins 7..4
  input  wire logic        i_port_read,     // core reads the port this phase
  input  wire logic        i_timer_zero_ovf,// counter passes T0_MAX to zero
  input  wire logic [7:0]  i_periph_evt,    // one-cycle pulses at flag positions
  // core sequencer
  input  wire logic        i_instr_end,     // last Q4 of the current instruction
  input  wire logic        i_gie_clear_instr,
  input  wire logic        i_return_from_irq_instr,
  input  wire logic        i_sleep_instr,
  input  wire logic [12:0] i_pc_next,
  output logic             o_irq_vector_req,
  output logic [12:0]      o_vector_addr,
  output logic             o_stack_push,
  output logic [12:0]      o_push_addr,
  output logic             o_insert_nop,
  output logic             o_sleeping,
  output logic             o_wake,
  output logic [1:0]       o_q_phase
);

  // ************************************************************
  // registers and helpers
  // ************************************************************
  logic [7:0]  intctl_r;
  logic [7:0]  pflags_r;
  logic [7:0]  penables_r;
  logic [7:0]  options_r;
  logic [1:0]  q_r;
  logic [2:0]  pin_sync_r;
  logic [3:0]  port_s1_r, port_s2_r, port_s3_r, port_last_r;
  logic        pin_last_r;
  logic        pin_seen_r;
  logic        block_r;
  logic [1:0]  lat_r;
  logic        lat_run_r;
  logic        pending;
  logic        core_any;
  logic        periph_any;
  logic        wr_en, rd_en;
  logic [7:0]  wdat;
  logic [7:0]  reg_idx;
  logic        pin_edge;
  logic        port_chg;
  logic [7:0]  rd_nxt;
  logic        accept;
  mcuic_pkg::mcuic_core_t core_nxt;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction

  assign reg_idx = i_paddr[mcuic_pkg::ADDR_LSB +: mcuic_pkg::IDX_W];
  assign wr_en   = i_psel & i_penable & i_pwrite & o_pready;
  assign rd_en   = i_psel & ~i_penable & ~i_pwrite;
  assign wdat    = i_pwdata[7:0];

  // ************************************************************
  // phase counter and input synchronisers
  // ************************************************************
  // q phase advances each clock; an instruction cycle spans four
  always_ff @(posedge i_core_clk) begin
    if (i_srst) q_r <= mcuic_pkg::Q1;
    else        q_r <= q_r + 2'h1;
  end

  // three stages; only stages two and three are compared
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pin_sync_r  <= 3'h0;
      port_s1_r   <= 4'h0;
      port_s2_r   <= 4'h0;
      port_s3_r   <= 4'h0;
    end else begin
      pin_sync_r  <= {pin_sync_r[1:0], i_ext_irq_pin};
      port_s1_r   <= i_port_hi_pins;
      port_s2_r   <= port_s1_r;
      port_s3_r   <= port_s2_r;
    end
  end

  // accepted level only moves once stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pin_last_r  <= 1'h0;
      port_last_r <= 4'h0;
    end else begin
      if (pin_sync_r[1] == pin_sync_r[2]) pin_last_r <= pin_sync_r[2];
      if (port_s2_r == port_s3_r) port_last_r <= port_s3_r;
    end
  end

  // edge polarity follows the select bit
  assign pin_edge = (pin_sync_r[1] == pin_sync_r[2]) && (pin_sync_r[2] != pin_last_r) &&
                    (pin_sync_r[2] == options_r[mcuic_pkg::BIT_EDGE]);  // R8
  // a change during the port read phase may be lost, as on the real port
  assign port_chg = (port_s2_r == port_s3_r) && (port_s3_r != port_last_r) &&
                    !i_port_read;  // R12 R11

  // edge is latched at any phase, flag only takes it at Q1
  always_ff @(posedge i_core_clk) begin
    if (i_srst)                         pin_seen_r <= 1'h0;
    else if (q_r == mcuic_pkg::Q1)      pin_seen_r <= pin_edge;  // R15
    else if (pin_edge)                  pin_seen_r <= 1'h1;
  end

  // ************************************************************
  // interrupt control register
  // ************************************************************
  // hardware set wins over a software write of zero
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      intctl_r <= (mcuic_pkg::INTCTL_RST & ~mcuic_pkg::INTCTL_KEEP) |
                  (i_power_on ? mcuic_pkg::INTCTL_RST : (intctl_r & mcuic_pkg::INTCTL_KEEP));
      // R2 R16
    end else begin
      if (wr_en && hit(reg_idx, mcuic_pkg::IDX_INTERRUPT_CONTROL)) intctl_r <= wdat;  // R14
      if (i_return_from_irq_instr) intctl_r[mcuic_pkg::BIT_GIE] <= 1'h1;  // R3
      if (i_gie_clear_instr || accept) intctl_r[mcuic_pkg::BIT_GIE] <= 1'h0;  // R4
      if (i_timer_zero_ovf) intctl_r[mcuic_pkg::BIT_T0F] <= 1'h1;  // R10 R5
      if (q_r == mcuic_pkg::Q1 && pin_seen_r) intctl_r[mcuic_pkg::BIT_PINF] <= 1'h1;  // R8 R5
      if (port_chg) intctl_r[mcuic_pkg::BIT_PCHF] <= 1'h1;  // R11 R5
    end
  end

  // ************************************************************
  // peripheral registers and options
  // ************************************************************
  // flags and enables share bit positions; bit 3 is unimplemented
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pflags_r <= mcuic_pkg::PERIPH_RST;  // R16
    end else begin
      // event set wins over a same-cycle software clear
      pflags_r <= (((wr_en && hit(reg_idx, mcuic_pkg::IDX_PERIPHERAL_FLAGS)) ? wdat : pflags_r)
                   | i_periph_evt) & mcuic_pkg::PERIPH_MASK;  // R5 R13 R20
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      penables_r <= mcuic_pkg::PERIPH_RST;
      options_r  <= mcuic_pkg::OPTIONS_RST;
    end else begin
      if (wr_en && hit(reg_idx, mcuic_pkg::IDX_PERIPHERAL_ENABLES))
        penables_r <= wdat & mcuic_pkg::PERIPH_MASK;  // R13
      if (wr_en && hit(reg_idx, mcuic_pkg::IDX_CORE_OPTIONS)) options_r <= wdat;
    end
  end

  // ************************************************************
  // request, latency and acceptance
  // ************************************************************
  assign core_any = (intctl_r[mcuic_pkg::BIT_T0E]  & intctl_r[mcuic_pkg::BIT_T0F]) |
                    (intctl_r[mcuic_pkg::BIT_PINE] & intctl_r[mcuic_pkg::BIT_PINF]) |
                    (intctl_r[mcuic_pkg::BIT_PCHE] & intctl_r[mcuic_pkg::BIT_PCHF]);
  assign periph_any = |(pflags_r & penables_r);
  // peripheral group needs its own enable to request, but wakes without it
  assign pending  = intctl_r[mcuic_pkg::BIT_GIE] &
                    (core_any | (intctl_r[mcuic_pkg::BIT_PGE] & periph_any));  // R1 R23
  // vector only at an instruction boundary so one and two cycle instructions match
  assign accept   = pending & lat_run_r & (lat_r == mcuic_pkg::LAT_SYNC_TCY) & i_instr_end &
                    !block_r & !i_gie_clear_instr;  // R6 R7

  // count instruction boundaries while a request stands
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !pending) begin
      lat_r     <= 2'h0;
      lat_run_r <= 1'h0;
    end else if (i_instr_end) begin
      lat_run_r <= 1'h1;
      if (lat_r != mcuic_pkg::LAT_SYNC_TCY) lat_r <= lat_r + 2'h1;  // R6
    end
  end

  // the cycle after a global-enable clear carries a forced no-op
  always_ff @(posedge i_core_clk) begin
    if (i_srst)                 block_r <= 1'h0;
    else if (i_gie_clear_instr) block_r <= 1'h1;  // R7
    else if (i_instr_end)       block_r <= 1'h0;
  end

  // ************************************************************
  // sleep and wake
  // ************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_sleeping <= 1'h0;
      o_wake     <= 1'h0;
    end else begin
      o_wake <= 1'h0;
      // an already pending enabled source turns sleep into a no-op
      if (i_sleep_instr && !(core_any || periph_any)) o_sleeping <= 1'h1;  // R22
      else if (o_sleeping && (core_any || periph_any)) begin
        o_sleeping <= 1'h0;  // R9 R21
        o_wake     <= 1'h1;
      end
    end
  end

  // ************************************************************
  // core outputs
  // ************************************************************
  // only the return address is pushed; working state is software's job
  always_comb begin
    core_nxt.req    = accept;  // R4 R19
    core_nxt.wake   = 1'h0;
    core_nxt.vector = mcuic_pkg::IRQ_VECTOR;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_irq_vector_req <= 1'h0;
      o_vector_addr    <= mcuic_pkg::IRQ_VECTOR;
      o_stack_push     <= 1'h0;
      o_push_addr      <= 13'h0000;
      o_insert_nop     <= 1'h0;
      o_q_phase        <= mcuic_pkg::Q1;
    end else begin
      o_irq_vector_req <= core_nxt.req;
      o_vector_addr    <= core_nxt.vector;
      o_stack_push     <= core_nxt.req;  // R17
      if (core_nxt.req) o_push_addr <= i_pc_next;
      o_insert_nop     <= i_gie_clear_instr;  // R7
      o_q_phase        <= q_r;
    end
  end

  // ************************************************************
  // apb read path: no wait state, data registered in setup
  // ************************************************************
  always_comb begin
    rd_nxt = 8'h00;
    if (hit(reg_idx, mcuic_pkg::IDX_INTERRUPT_CONTROL))  rd_nxt = intctl_r;
    if (hit(reg_idx, mcuic_pkg::IDX_PERIPHERAL_FLAGS))   rd_nxt = pflags_r;
    if (hit(reg_idx, mcuic_pkg::IDX_PERIPHERAL_ENABLES)) rd_nxt = penables_r;
    if (hit(reg_idx, mcuic_pkg::IDX_CORE_OPTIONS))       rd_nxt = options_r;
    if (hit(reg_idx, mcuic_pkg::IDX_CORE_STATUS))        rd_nxt = {6'h00, o_sleeping, pending};
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pready  <= 1'h0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'h0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      if (rd_en) o_prdata <= {24'h000000, rd_nxt};
      o_pslverr <= i_psel & ~i_penable &
                   !(hit(reg_idx, mcuic_pkg::IDX_INTERRUPT_CONTROL) ||
                     hit(reg_idx, mcuic_pkg::IDX_PERIPHERAL_FLAGS) ||
                     hit(reg_idx, mcuic_pkg::IDX_PERIPHERAL_ENABLES) ||
                     hit(reg_idx, mcuic_pkg::IDX_CORE_OPTIONS) ||
                     hit(reg_idx, mcuic_pkg::IDX_CORE_STATUS));
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  AST_GIE_GATE: assert property (@(posedge i_core_clk) disable iff (i_srst) // R1
    !intctl_r[mcuic_pkg::BIT_GIE] |=> !o_irq_vector_req) else $error("vector without enable");
  AST_RST_GIE: assert property (@(posedge i_core_clk) // R2
    i_srst |=> !intctl_r[mcuic_pkg::BIT_GIE]) else $error("enable survived reset");
  AST_RET_SET: assert property (@(posedge i_core_clk) disable iff (i_srst) // R3
    i_return_from_irq_instr && !i_gie_clear_instr && !accept |=> intctl_r[mcuic_pkg::BIT_GIE])
    else $error("return did not set enable");
  AST_ACCEPT: assert property (@(posedge i_core_clk) disable iff (i_srst) // R4
    accept |=> o_irq_vector_req && o_stack_push && !intctl_r[mcuic_pkg::BIT_GIE] &&
    o_vector_addr == mcuic_pkg::IRQ_VECTOR) else $error("bad accept");
  AST_T0_FLAG: assert property (@(posedge i_core_clk) disable iff (i_srst) // R10
    i_timer_zero_ovf |=> intctl_r[mcuic_pkg::BIT_T0F]) else $error("timer flag lost");
  AST_PFLAG: assert property (@(posedge i_core_clk) disable iff (i_srst) // R5
    i_periph_evt[0] |=> pflags_r[0]) else $error("peripheral flag lost");
  AST_NOP: assert property (@(posedge i_core_clk) disable iff (i_srst) // R7
    i_gie_clear_instr |=> o_insert_nop && !o_irq_vector_req) else $error("no nop after clear");
  AST_PIN_Q1: assert property (@(posedge i_core_clk) disable iff (i_srst) // R15
    $rose(intctl_r[mcuic_pkg::BIT_PINF]) |-> $past(q_r) == mcuic_pkg::Q1)
    else $error("pin flag outside first phase");
  AST_SLEEP_NOP: assert property (@(posedge i_core_clk) disable iff (i_srst) // R22
    i_sleep_instr && (core_any || periph_any) && !o_sleeping |=> !o_sleeping)
    else $error("slept with pending source");
  // a qualified pin edge reaches the flag by the next first phase
  AST_PIN_EDGE: assert property (@(posedge i_core_clk) disable iff (i_srst) // R8
    pin_edge |-> ##[1:5] intctl_r[mcuic_pkg::BIT_PINF]) else $error("pin edge lost");
  AST_PCH_SET: assert property (@(posedge i_core_clk) disable iff (i_srst) // R11
    port_chg |=> intctl_r[mcuic_pkg::BIT_PCHF]) else $error("port change flag lost");
  AST_PUSH_ADDR: assert property (@(posedge i_core_clk) disable iff (i_srst) // R17
    accept |=> o_push_addr == $past(i_pc_next)) else $error("wrong return address pushed");
  AST_WAKE: assert property (@(posedge i_core_clk) disable iff (i_srst) // R21
    o_sleeping && (core_any || periph_any) |=> o_wake && !o_sleeping)
    else $error("enabled source did not wake");
  AST_GAP: assert property (@(posedge i_core_clk) disable iff (i_srst) // R13
    !pflags_r[mcuic_pkg::BIT_GAP] && !penables_r[mcuic_pkg::BIT_GAP])
    else $error("unimplemented peripheral bit set");

endmodule

// File: dv/mcuic_core_model.sv
// core sequencer model: instruction boundaries, instruction pulses and program counter
`timescale 1ns/1ns
module mcuic_core_model (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  // controller status
  input  wire logic [1:0]  i_q_phase,
  input  wire logic        i_sleeping,
  input  wire logic        i_vec_req,
  input  wire logic [12:0] i_vec_addr,
  // bench command: 1 clear enable, 2 return, 3 sleep
  input  wire logic [1:0]  i_cmd,
  // sequencer outputs
  output logic             o_instr_end,
  output logic             o_gie_clear,
  output logic             o_ret,
  output logic             o_sleep,
  output logic [12:0]      o_pc_next
);
  // a sleeping core retires nothing, so boundaries stop until wake
  assign o_instr_end = (i_q_phase == mcuic_pkg::Q4) && !i_sleeping;
  // commands retire only at a boundary, as a real core issues them
  assign o_gie_clear = o_instr_end && (i_cmd == 2'h1);
  assign o_ret       = o_instr_end && (i_cmd == 2'h2);
  assign o_sleep     = o_instr_end && (i_cmd == 2'h3);
  // program counter: a vector load wins over the increment
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pc_next <= 13'h0001;
    end else if (i_vec_req) begin
      o_pc_next <= i_vec_addr + 13'h0001;
    end else if (o_instr_end) begin
      o_pc_next <= o_pc_next + 13'h0001;
    end
  end
endmodule

// File: dv/mcuic_ctrl_bench.sv
// self-checking bench for the interrupt controller: registers, events, vectoring, sleep
`timescale 1ns/1ns
module mcuic_ctrl_bench;
  // ************************************************************
  // signals, register table and tasks
  // ************************************************************
  typedef struct packed {
    logic [7:0]  idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        err;
  } mcuic_row_t;
  localparam logic [7:0] CTL = mcuic_pkg::IDX_INTERRUPT_CONTROL;
  localparam logic [7:0] PFL = mcuic_pkg::IDX_PERIPHERAL_FLAGS;
  localparam logic [7:0] PEN = mcuic_pkg::IDX_PERIPHERAL_ENABLES;
  localparam logic [7:0] OPT = mcuic_pkg::IDX_CORE_OPTIONS;
  localparam int         TCY = mcuic_pkg::Q_PER_TCY;
  logic        clk = 1'h0, srst = 1'h1, pwr = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, pin = 1'h0, ovf = 1'h0, iend, gclr, ret, slp;
  logic [3:0]  port = 4'h0;
  logic        prd = 1'h0;  // core port read window
  logic [7:0]  periph = 8'h0;
  logic [1:0]  cmd = 2'h0, qph;
  logic [12:0] pc, vaddr, paddr_push;
  logic        vreq, push, nop, sleeping, wake;
  int          failures = 0, compares = 0, nvec = 0, nnop = 0, nwake = 0, cyc = 0, lat, v0;
  mcuic_row_t  rows [8] = '{'{PEN, 32'hFF, 32'hF7, 1'h0}, '{PEN, 32'h0, 32'h0, 1'h0},
                            '{OPT, 32'hBF, 32'hBF, 1'h0}, '{OPT, 32'hFF, 32'hFF, 1'h0},
                            '{PFL, 32'h0, 32'h0, 1'h0}, '{CTL, 32'h78, 32'h78, 1'h0},
                            '{CTL, 32'h0, 32'h0, 1'h0}, '{8'h40, 32'h12, 32'h0, 1'h1}};

  mcuic_ctrl dut (.i_core_clk(clk), .i_srst(srst), .i_power_on(pwr), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_ext_irq_pin(pin),
    .i_port_hi_pins(port), .i_port_read(prd), .i_timer_zero_ovf(ovf), .i_periph_evt(periph),
    .i_instr_end(iend), .i_gie_clear_instr(gclr), .i_return_from_irq_instr(ret),
    .i_sleep_instr(slp), .i_pc_next(pc), .o_irq_vector_req(vreq), .o_vector_addr(vaddr),
    .o_stack_push(push), .o_push_addr(paddr_push), .o_insert_nop(nop),
    .o_sleeping(sleeping), .o_wake(wake), .o_q_phase(qph));
  mcuic_core_model core (.i_core_clk(clk), .i_srst(srst), .i_q_phase(qph),
    .i_sleeping(sleeping), .i_vec_req(vreq), .i_vec_addr(vaddr), .i_cmd(cmd),
    .o_instr_end(iend), .o_gie_clear(gclr), .o_ret(ret), .o_sleep(slp), .o_pc_next(pc));

  // clock, event counters and the hang limit (a run needs well under 2000 cycles)
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (vreq === 1'h1) nvec++;
    if (nop === 1'h1) nnop++;
    if (wake === 1'h1) nwake++;
    cyc++;
    if (cyc == 6000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] e, input logic er);
    apb(idx, 1'h0, 32'h0);
    chk($sformatf("reg %h", idx), e, rdat);
    chk("slverr", {31'h0, er}, {31'h0, rerr});
  endtask
  task automatic rst(input logic pon);
    @(posedge clk);
    srst <= 1'h1;
    pwr <= pon;
    idle(2);
    srst <= 1'h0;
    pwr <= 1'h0;
  endtask
  // one-cycle event pulses from the timer and the peripherals
  task automatic ev(input logic [7:0] pe, input logic t0);
    @(posedge clk);
    periph <= pe;
    ovf <= t0;
    @(posedge clk);
    periph <= 8'h0;
    ovf <= 1'h0;
  endtask
  // command held until the core model retires it at a boundary
  task automatic instr(input logic [1:0] k);
    int n;
    n = 0;
    @(posedge clk);
    cmd <= k;
    do begin
      @(posedge clk);
      n++;
    end while (iend !== 1'h1 && n < 20);
    chk("boundary", 32'h1, {31'h0, iend});
    cmd <= 2'h0;
  endtask
  // waits for the vector request and checks what comes with it
  task automatic wait_vec(input int lim);
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (vreq !== 1'h1 && lat < 60);
    chk("latency in bound", 32'h1, {31'h0, lat <= lim});
    chk("vector", {19'h0, mcuic_pkg::IRQ_VECTOR}, {19'h0, vaddr});
    chk("push", 32'h1, {31'h0, push});
    // the model already stepped past the accepting boundary
    chk("push addr", {19'h0, pc - 13'h1}, {19'h0, paddr_push});
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    rst(1'h1);
    rc(CTL, 32'h0, 1'h0);
    rc(PFL, 32'h0, 1'h0);
    rc(PEN, 32'h0, 1'h0);
    rc(OPT, {24'h0, mcuic_pkg::OPTIONS_RST}, 1'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      apb(rows[i].idx, 1'h1, rows[i].wdata);
      rc(rows[i].idx, rows[i].rdata, rows[i].err);
    end
    $display("test table done");
    // every source with all enables clear: flags set, nothing vectors
    ev(8'hFF, 1'h1);
    @(posedge clk);
    pin <= 1'h1;
    port <= 4'h5;
    idle(10);
    rc(CTL, 32'h07, 1'h0);
    rc(PFL, {24'h0, mcuic_pkg::PERIPH_MASK}, 1'h0);
    chk("vectors", 32'h0, nvec);
    $display("test flags done");
    // warm reset keeps the port-change flag, power-up clears it
    pin <= 1'h0;
    port <= 4'h0;
    idle(10);
    rst(1'h0);
    rc(CTL, 32'h01, 1'h0);
    rc(PFL, 32'h0, 1'h0);
    rst(1'h1);
    rc(CTL, 32'h0, 1'h0);
    $display("test reset kinds done");
    // timer source accepted, enable cleared, return restores it
    apb(CTL, 1'h1, 32'hA0);
    ev(8'h0, 1'h1);
    wait_vec(4 * TCY);
    rc(CTL, 32'h24, 1'h0);
    apb(CTL, 1'h1, 32'h20);
    v0 = nvec;
    instr(2'h2);
    rc(CTL, 32'hA0, 1'h0);
    idle(20);
    chk("no repeat", v0, nvec);
    $display("test accept done");
    // peripheral source needs the group enable as well
    apb(PEN, 1'h1, 32'h01);
    ev(8'h01, 1'h0);
    idle(20);
    chk("group gated", v0, nvec);
    apb(CTL, 1'h1, 32'hE0);
    wait_vec(4 * TCY);
    apb(PFL, 1'h1, 32'h0);
    apb(PEN, 1'h1, 32'h0);
    $display("test group done");
    // clear-enable instruction: nop inserted, request held pending
    apb(CTL, 1'h1, 32'hA0);
    v0 = nvec;
    lat = nnop;
    ev(8'h0, 1'h1);
    instr(2'h1);
    idle(30);
    chk("nop", 32'h1, {31'h0, nnop != lat});
    chk("held", v0, nvec);
    instr(2'h2);
    wait_vec(4 * TCY);
    $display("test clear done");
    // pending enabled flag with enable clear: sleep acts as nop
    instr(2'h3);
    idle(8);
    chk("no sleep", 32'h0, {31'h0, sleeping});
    // falling pin edge wakes, execution continues without vector
    apb(OPT, 1'h1, 32'hBF);
    pin <= 1'h1;
    idle(10);
    apb(CTL, 1'h1, 32'h10);
    v0 = nvec;
    lat = nwake;
    instr(2'h3);
    idle(4);
    chk("asleep", 32'h1, {31'h0, sleeping});
    rc(mcuic_pkg::IDX_CORE_STATUS, 32'h02, 1'h0);
    pin <= 1'h0;
    idle(30);
    chk("woken", 32'h1, {31'h0, nwake != lat});
    chk("awake", 32'h0, {31'h0, sleeping});
    chk("no vector", v0, nvec);
    rc(CTL, 32'h12, 1'h0);
    // rising edge wakes with enable set: vectors
    apb(OPT, 1'h1, 32'hFF);
    apb(CTL, 1'h1, 32'h90);
    instr(2'h3);
    idle(4);
    chk("asleep", 32'h1, {31'h0, sleeping});
    pin <= 1'h1;
    wait_vec(10 * TCY);
    rc(CTL, 32'h12, 1'h0);
    $display("test sleep done");
    // a port change inside a held read window is lost; outside it sets the flag
    apb(CTL, 1'h1, 32'h0);
    prd <= 1'h1;
    port <= 4'h8;
    idle(10);
    prd <= 1'h0;
    rc(CTL, 32'h0, 1'h0);
    port <= 4'h0;
    idle(10);
    rc(CTL, 32'h01, 1'h0);
    $display("test port read done");
    wrap_up();
  end
endmodule
